// ==== rtl/atc_pkg.sv ====
// Constants, field positions and states for the address translation control block.
// Operation
// - Load-status copies the whole 16-bit accumulator word into translation status.
// - Status bits 0 and 13 together choose the next user table.
// - Status bits 6-8 pick the table the next table load fills.
// - Status bit 15 arms translation after next indirect or return event.
// - Setting user enable inhibits interrupts and waits for the trigger event.
// - On the trigger event, interrupts are released and user translation begins.
// - Trigger is first indirection level or a pop, pop-jump, return, restore.
// - Supervisor window maps only logical page 31 while untranslated.
// - Window load takes bits 6-15 as physical page, ignores bits 0-5.
// - A changed window takes effect on the very next fetch through it.
// - I/O bus clear returns the unit to identity translation.
package atc_pkg;
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned LPAGE_W     = 5;
   localparam int unsigned PPAGE_W     = 10;
   localparam int unsigned ADDR_W      = 15;
   localparam int unsigned OFFS_W      = 10;
   // Bit numbers are vector indices: bit 0 is the word's lsb; the header above counts bits from the msb.
   localparam int unsigned ST_TSEL_HI  = 15;
   localparam int unsigned ST_TSEL_LO  = 2;
   localparam int unsigned ST_MAP_LSB  = 7;
   localparam int unsigned ST_EAL      = 6;
   localparam int unsigned ST_IOP      = 5;
   localparam int unsigned ST_WP       = 4;
   localparam int unsigned ST_DEREF    = 3;
   localparam int unsigned ST_CHAN     = 1;
   localparam int unsigned ST_UE       = 0;
   localparam int unsigned PC_LP_LSB   = 10;
   localparam int unsigned PC_MAP_LSB  = 7;
   localparam logic [LPAGE_W-1:0] SUPV_PAGE = 5'h1f;
   localparam logic [WORD_W-1:0]  STATUS_RST = 16'h0000;
   localparam logic [PPAGE_W-1:0] WINDOW_RST = 10'h01f;

   typedef enum logic [1:0] {
      ATC_IDLE  = 2'b00,
      ATC_ARMED = 2'b01,
      ATC_USER  = 2'b11
   } atc_state_e;
endpackage

// ==== rtl/atc_address_translation_control.sv ====
// Control logic of the address translation unit: status, window, page check.
`timescale 1ns/1ps
module atc_address_translation_control
   import atc_pkg::*;
(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // I/O instruction strobes, accumulator data
   input  wire logic                 out_a_transfer,
   input  wire logic                 out_b_transfer,
   input  wire logic                 out_c_transfer,
   input  wire logic                 io_bus_clear,
   input  wire logic [WORD_W-1:0]    accData,
   // Processor events that release user translation
   input  wire logic                 firstIndirectDone,
   input  wire logic                 pop_block_return,
   input  wire logic                 pop_jump_return,
   input  wire logic                 subroutine_return,
   input  wire logic                 state_restore_return,
   // Logical address of the current untranslated reference
   input  wire logic [ADDR_W-1:0]    logicalAddr,
   // Translation control outputs
   output logic [WORD_W-1:0]         translationStatus,
   output logic [1:0]                user_table_select,
   output logic [2:0]                table_load_instruction,
   output logic                      effective_address_load_enable,
   output logic                      ioProtectEnable,
   output logic                      writeProtectEnable,
   output logic                      deref_protect_enable,
   output logic                      channel_translation_enable,
   output logic                      userTranslateOn,
   output logic                      interruptInhibit,
   output logic [PPAGE_W-1:0]        supervisorWindowPage,
   output logic                      windowHit,
   output logic [ADDR_W-1:0]         physicalAddr,
   output logic [LPAGE_W-1:0]        checkLogicalPage,
   output logic [2:0]                checkTableSelect
);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   atc_state_e          state, next_state;
   logic [WORD_W-1:0]   next_status;
   logic [PPAGE_W-1:0]  next_window;
   logic [LPAGE_W-1:0]  next_lp;
   logic [2:0]          next_sel;
   logic                releaseEvent;
   logic                next_hit;
   logic [ADDR_W-1:0]   next_phys;

   // The physical address leaving this block is only 15 bits wide, so just the
   // low page bits of the window survive; higher physical pages need the full
   // translation path outside this block.
   function automatic logic [LPAGE_W-1:0] windowMap(input logic [ADDR_W-1:0] a,
                                                     input logic [PPAGE_W-1:0] p);
      windowMap = p[LPAGE_W-1:0];
      if (a[ADDR_W-1 -: LPAGE_W] != SUPV_PAGE)
         windowMap = a[ADDR_W-1 -: LPAGE_W];
   endfunction

   assign releaseEvent = firstIndirectDone | pop_block_return | pop_jump_return
                       | subroutine_return | state_restore_return;

   always_comb begin
      next_state  = state;
      next_status = translationStatus;
      next_window = supervisorWindowPage;
      next_lp     = checkLogicalPage;
      next_sel    = checkTableSelect;
      if (out_a_transfer) begin
         next_status = accData;
      end
      if (out_b_transfer) begin
         next_window = accData[PPAGE_W-1:0];
      end
      if (out_c_transfer) begin
         next_lp  = accData[PC_LP_LSB +: LPAGE_W];
         next_sel = accData[PC_MAP_LSB +: 3];
      end
      unique case (state)
         ATC_IDLE: begin
            if (out_a_transfer && accData[ST_UE]) begin
               next_state = ATC_ARMED;
            end
         end
         ATC_ARMED: begin
            if (releaseEvent) begin
               next_state = ATC_USER;
            end
         end
         ATC_USER: begin
            // A fresh user-enable write re-arms the lockout, so the next user
            // only starts translating at a clean indirect or return point.
            if (out_a_transfer && accData[ST_UE]) begin
               next_state = ATC_ARMED;
            end else if (out_a_transfer) begin
               next_state = ATC_IDLE;
            end
         end
         default: next_state = ATC_IDLE;
      endcase
      if (io_bus_clear) begin
         next_state  = ATC_IDLE;
         next_status = STATUS_RST;
         next_window = WINDOW_RST;
      end
      // Window mapping applies only while untranslated; it uses the fresh page.
      next_hit  = (state != ATC_USER)
                  && (logicalAddr[ADDR_W-1 -: LPAGE_W] == SUPV_PAGE);
      next_phys = {windowMap(logicalAddr, next_window),
                   logicalAddr[OFFS_W-1:0]};
      if (state == ATC_USER) begin
         next_phys = logicalAddr;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state                <= ATC_IDLE;
         translationStatus    <= STATUS_RST;
         supervisorWindowPage <= WINDOW_RST;
         checkLogicalPage     <= '0;
         checkTableSelect     <= '0;
         windowHit            <= 1'b0;
         physicalAddr         <= '0;
         user_table_select    <= '0;
         table_load_instruction <= '0;
         effective_address_load_enable <= 1'b0;
         ioProtectEnable      <= 1'b0;
         writeProtectEnable   <= 1'b0;
         deref_protect_enable <= 1'b0;
         channel_translation_enable <= 1'b0;
         userTranslateOn      <= 1'b0;
         interruptInhibit     <= 1'b0;
      end else begin
         state                <= next_state;
         translationStatus    <= next_status;
         supervisorWindowPage <= next_window;
         checkLogicalPage     <= next_lp;
         checkTableSelect     <= next_sel;
         windowHit            <= next_hit;
         physicalAddr         <= next_phys;
         user_table_select    <= {next_status[ST_TSEL_HI], next_status[ST_TSEL_LO]};
         table_load_instruction <= next_status[ST_MAP_LSB +: 3];
         effective_address_load_enable <= next_status[ST_EAL];
         ioProtectEnable      <= next_status[ST_IOP];
         writeProtectEnable   <= next_status[ST_WP];
         deref_protect_enable <= next_status[ST_DEREF];
         channel_translation_enable <= next_status[ST_CHAN];
         userTranslateOn      <= (next_state == ATC_USER);
         interruptInhibit     <= (next_state == ATC_ARMED);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_status_load;
      @(posedge mclk) disable iff (sys_rst)
      out_a_transfer && !io_bus_clear |=> translationStatus == $past(accData);
   endproperty
   a_status_load: assert property (p_status_load) else $error("status not loaded");

   property p_arm;
      @(posedge mclk) disable iff (sys_rst)
      out_a_transfer && accData[ST_UE] && !io_bus_clear && state != ATC_ARMED
         |=> interruptInhibit && !userTranslateOn;
   endproperty
   a_arm: assert property (p_arm) else $error("arming did not inhibit");

   sequence s_armed_event;
      interruptInhibit && releaseEvent && !io_bus_clear && !out_a_transfer;
   endsequence
   property p_release;
      @(posedge mclk) disable iff (sys_rst)
      s_armed_event |=> userTranslateOn && !interruptInhibit;
   endproperty
   a_release: assert property (p_release) else $error("release missed");

   property p_wait;
      @(posedge mclk) disable iff (sys_rst)
      interruptInhibit && !releaseEvent && !io_bus_clear |=> interruptInhibit;
   endproperty
   a_wait: assert property (p_wait) else $error("left armed early");

   property p_clear;
      @(posedge mclk) disable iff (sys_rst)
      io_bus_clear |=> !userTranslateOn && !interruptInhibit
                       && translationStatus == STATUS_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_window;
      @(posedge mclk) disable iff (sys_rst)
      out_b_transfer && !io_bus_clear |=> supervisorWindowPage == $past(accData[PPAGE_W-1:0]);
   endproperty
   a_window: assert property (p_window) else $error("window not loaded");

   property p_fresh;
      @(posedge mclk) disable iff (sys_rst)
      out_b_transfer && !io_bus_clear && state != ATC_USER
         && logicalAddr[ADDR_W-1 -: LPAGE_W] == SUPV_PAGE
         |=> physicalAddr[ADDR_W-1:OFFS_W] == $past(accData[LPAGE_W-1:0]) && windowHit;
   endproperty
   a_fresh: assert property (p_fresh) else $error("stale window used");

   property p_check;
      @(posedge mclk) disable iff (sys_rst)
      out_c_transfer |=> checkLogicalPage == $past(accData[PC_LP_LSB +: LPAGE_W])
                         && checkTableSelect == $past(accData[PC_MAP_LSB +: 3]);
   endproperty
   a_check: assert property (p_check) else $error("page check not latched");

   property p_chan_enable;
      @(posedge mclk) disable iff (sys_rst)
      out_a_transfer && !io_bus_clear |=> channel_translation_enable == $past(accData[ST_CHAN]);
   endproperty
   a_chan_enable: assert property (p_chan_enable) else $error("channel enable wrong");

endmodule

// ==== tb/atc_cpu_model.sv ====
// Processor core model that issues I/O transfers, release events and addresses.
`timescale 1ns/1ps
module atc_cpu_model
   import atc_pkg::*;
(
   // Clock and state seen from the unit
   input  wire logic              mclk,
   input  wire logic              userTranslateOn,
   // I/O transfers
   output logic                   out_a_transfer,
   output logic                   out_b_transfer,
   output logic                   out_c_transfer,
   output logic                   io_bus_clear,
   output logic [WORD_W-1:0]      accData,
   // Release events and current address
   output logic                   firstIndirectDone,
   output logic                   pop_block_return,
   output logic                   pop_jump_return,
   output logic                   subroutine_return,
   output logic                   state_restore_return,
   output logic [ADDR_W-1:0]      logicalAddr
);
   logic [4:0] evt = 5'h00;

   assign {state_restore_return, subroutine_return, pop_jump_return, pop_block_return,
           firstIndirectDone} = evt;

   initial begin
      {io_bus_clear, out_c_transfer, out_b_transfer, out_a_transfer} = 4'h0;
      accData = 16'h0000;
      logicalAddr = 15'h0000;
   end

   // Strobe mask is {clear, page check, window, status}; the word stands one cycle.
   task automatic xfer(input logic [3:0] strb, input logic [WORD_W-1:0] d);
      @(posedge mclk);
      #1;
      if (strb[1] && userTranslateOn === 1'b1) begin
         strb[1] = 1'b0;
      end
      {io_bus_clear, out_c_transfer, out_b_transfer, out_a_transfer} = strb;
      accData = d;
      @(posedge mclk);
      #1;
      {io_bus_clear, out_c_transfer, out_b_transfer, out_a_transfer} = 4'h0;
      // A released bus must not keep showing the old word.
      accData = ~d;
   endtask

   task automatic fire(input int idx);
      @(posedge mclk);
      #1;
      evt = 5'h01 << idx;
      @(posedge mclk);
      #1;
      evt = 5'h00;
   endtask

   // The address is set after one edge and is registered at the next; its translation shows after that edge.
   task automatic addr(input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      #1;
      logicalAddr = a;
      @(posedge mclk);
      #1;
   endtask
endmodule

// ==== tb/test_atc_address_translation_control.sv ====
// Self-checking testbench for the address translation control block.
`timescale 1ns/1ps
module test_atc_address_translation_control
   import atc_pkg::*;
;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic out_a_transfer, out_b_transfer, out_c_transfer, io_bus_clear;
   logic [WORD_W-1:0] accData, translationStatus, w;
   logic firstIndirectDone, pop_block_return, pop_jump_return;
   logic subroutine_return, state_restore_return;
   logic [ADDR_W-1:0] logicalAddr, physicalAddr;
   logic [1:0] user_table_select;
   logic [2:0] table_load_instruction, checkTableSelect;
   logic effective_address_load_enable, ioProtectEnable, writeProtectEnable;
   logic deref_protect_enable, channel_translation_enable, userTranslateOn;
   logic interruptInhibit, windowHit;
   logic [PPAGE_W-1:0] supervisorWindowPage;
   logic [LPAGE_W-1:0] checkLogicalPage;
   int fails = 0;
   int checks = 0;
   int cyc = 0;

   atc_address_translation_control u_dut (
      .mclk                          (mclk),
      .sys_rst                       (sys_rst),
      .out_a_transfer                (out_a_transfer),
      .out_b_transfer                (out_b_transfer),
      .out_c_transfer                (out_c_transfer),
      .io_bus_clear                  (io_bus_clear),
      .accData                       (accData),
      .firstIndirectDone             (firstIndirectDone),
      .pop_block_return              (pop_block_return),
      .pop_jump_return               (pop_jump_return),
      .subroutine_return             (subroutine_return),
      .state_restore_return          (state_restore_return),
      .logicalAddr                   (logicalAddr),
      .translationStatus             (translationStatus),
      .user_table_select             (user_table_select),
      .table_load_instruction        (table_load_instruction),
      .effective_address_load_enable (effective_address_load_enable),
      .ioProtectEnable               (ioProtectEnable),
      .writeProtectEnable            (writeProtectEnable),
      .deref_protect_enable          (deref_protect_enable),
      .channel_translation_enable    (channel_translation_enable),
      .userTranslateOn               (userTranslateOn),
      .interruptInhibit              (interruptInhibit),
      .supervisorWindowPage          (supervisorWindowPage),
      .windowHit                     (windowHit),
      .physicalAddr                  (physicalAddr),
      .checkLogicalPage              (checkLogicalPage),
      .checkTableSelect              (checkTableSelect)
   );

   atc_cpu_model u_cpu (
      .mclk                 (mclk),
      .userTranslateOn      (userTranslateOn),
      .out_a_transfer       (out_a_transfer),
      .out_b_transfer       (out_b_transfer),
      .out_c_transfer       (out_c_transfer),
      .io_bus_clear         (io_bus_clear),
      .accData              (accData),
      .firstIndirectDone    (firstIndirectDone),
      .pop_block_return     (pop_block_return),
      .pop_jump_return      (pop_jump_return),
      .subroutine_return    (subroutine_return),
      .state_restore_return (state_restore_return),
      .logicalAddr          (logicalAddr)
   );

   initial begin
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang is cut off well past the roughly 70 cycles the tests need.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         stop_test();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      chk(translationStatus, 16'h0000);
      chk(supervisorWindowPage, WINDOW_RST);
      for (int i = 0; i < 8; i++) begin
         w = 16'h0000;
         w[14:10] = 5'h15;
         w[9:7] = i[2:0];
         w[15] = i[0];
         w[2] = i[1];
         w[6:3] = {i[0], i[1], i[2], ~i[0]};
         w[1] = i[2];
         u_cpu.xfer(4'h1, w);
         chk(translationStatus, w);
         chk(user_table_select, {w[15], w[2]});
         chk(table_load_instruction, w[9:7]);
         chk({effective_address_load_enable, ioProtectEnable, writeProtectEnable,
              deref_protect_enable}, w[6:3]);
         chk({channel_translation_enable, userTranslateOn}, {w[1], 1'b0});
      end
      u_cpu.xfer(4'h2, 16'hfd2a);
      chk(supervisorWindowPage, 10'h12a);
      u_cpu.addr(15'h7c05);
      chk({windowHit, physicalAddr}, {1'b1, 15'h2805});
      u_cpu.xfer(4'h2, 16'h0013);
      chk(physicalAddr, 15'h4c05);
      u_cpu.addr(15'h7805);
      chk({windowHit, physicalAddr}, {1'b0, 15'h7805});
      u_cpu.xfer(4'h4, 16'h56c0);
      chk({checkLogicalPage, checkTableSelect}, {5'h15, 3'h5});
      for (int e = 0; e < 5; e++) begin
         u_cpu.xfer(4'h1, 16'h8001);
         chk(interruptInhibit, 1'b1);
         u_cpu.addr(15'h7c05);
         chk({interruptInhibit, userTranslateOn}, 2'b10);
         u_cpu.fire(e);
         chk({interruptInhibit, userTranslateOn}, 2'b01);
         chk(user_table_select, 2'b10);
      end
      u_cpu.addr(15'h7c05);
      chk({windowHit, physicalAddr}, {1'b0, 15'h7c05});
      u_cpu.xfer(4'h2, 16'h03ff);
      chk(supervisorWindowPage, 10'h013);
      u_cpu.xfer(4'h9, 16'h8001);
      chk(translationStatus, 16'h0000);
      chk({userTranslateOn, interruptInhibit}, 2'b00);
      chk(supervisorWindowPage, WINDOW_RST);
      u_cpu.addr(15'h7c05);
      chk(physicalAddr, 15'h7c05);
      stop_test();
   end
endmodule
